// File: sim/drm_soc_model.sv
// Behavioural SoC port model: host role, L2 entry and start of resume pulses
`timescale 1ns/1ps
module drm_soc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] want_l2,
   input wire logic [1:0] want_sor,
   input wire logic [1:0] want_prst,
   output logic [1:0] host_mode,
   output logic [1:0] suspended,
   output logic [1:0] l2_suspend_command,
   output logic [1:0] start_of_resume_signal,
   output logic [1:0] port_reset_ann
);
   logic [1:0] l2_d;
   logic [1:0] sor_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {host_mode, suspended, l2_suspend_command, start_of_resume_signal} <= 8'h00;
         {l2_d, sor_d} <= 4'h0;
         port_reset_ann <= 2'h0;
      end else begin
         host_mode <= 2'h3;
         port_reset_ann <= want_prst;
         l2_d <= want_l2;
         sor_d <= want_sor;
         // One-edge pulses, as a real port only announces once
         l2_suspend_command <= want_l2 & ~l2_d;
         start_of_resume_signal <= want_sor & ~sor_d;
         suspended <= (suspended | (want_l2 & ~l2_d)) & ~(want_sor & ~sor_d);
      end
   end
endmodule : drm_soc_model

// File: sim/test_drm_top.sv
// Self-checking bench for the repeater mode control top
`timescale 1ns/1ps
module test_drm_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, cross_sel = 1, gpz = 1, power_down, xbar_swap;
   logic [1:0] tpi = 2'h0, tpo, tpoe, usb_wake = 2'h0, want_l2 = 2'h0, want_sor = 2'h0;
   logic [1:0] hm, sus, l2c, sor, pra, rdy, uart, rk, hrw, hse0, sef, atf, strap;
   logic irq_out, irq_oe, rcm = 1;
   logic [1:0] se0 = 2'h0, att = 2'h0, want_prst = 2'h0;
   int n_fail = 0, n_checks = 0;
   drm_soc_model soc (.pclk(pclk), .presetn(presetn), .want_l2(want_l2), .want_sor(want_sor),
      .want_prst(want_prst), .host_mode(hm), .suspended(sus), .l2_suspend_command(l2c),
      .start_of_resume_signal(sor), .port_reset_ann(pra));
   drm_top #(.XLAT_CYC(50), .DEB_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reg_ctrl_mode(rcm), .cross_sel(cross_sel),
      .general_pin_zero(gpz), .tuning_pin_in(tpi), .tuning_pin_out(tpo),
      .tuning_pin_oe(tpoe), .irq_output_pin_out(irq_out), .irq_output_pin_oe(irq_oe),
      .host_mode(hm), .suspended(sus), .l2_suspend_command(l2c),
      .start_of_resume_signal(sor), .port_reset_ann(pra), .usb_wake(usb_wake),
      .usb_se0(se0), .usb_attach(att), .power_down(power_down), .xbar_swap(xbar_swap),
      .rpt_ready(rdy), .uart_bypass(uart), .usb_resume_k(rk), .emb_hold_rwake(hrw),
      .emb_hold_se0(hse0), .emb_se0_fwd(sef), .emb_attach_fwd(atf), .tuning_strap(strap));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick
   // Master holds the whole request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic t_boot;
      chk("strap", 2'h0, strap);
      chk("tune oe", 2'h0, tpoe);
      tick(40);
      chk("swap early", 1'b0, xbar_swap);
      tick(20);
      chk("swap latched", 1'b1, xbar_swap);
      @(posedge pclk) cross_sel <= 0;
      tick(120);
      chk("ready early", 2'h0, rdy);
      tick(30);
      chk("ready", 2'h3, rdy);
      chk("swap held", 1'b1, xbar_swap);
      apb(0, 8'h00, 0);
      chk("ctrl reset", 32'h60, rd);
      apb(0, 8'h20, 0);
      chk("unmapped err", 1'b1, er);
      chk("unmapped data", 32'h0, rd);
   endtask : t_boot
   task automatic t_wake;
      apb(1, 8'h04, 32'h81);
      apb(1, 8'h0C, 32'h01);
      @(posedge pclk) want_l2 <= 2'h3;
      tick(4);
      @(posedge pclk) usb_wake <= 2'h3;
      tick(4);
      chk("resume k", 2'h3, rk);
      chk("hold se0 p0", 1'b1, hse0[0]);
      chk("hold wake p1", 1'b1, hrw[1]);
      chk("irq pin", 2'h2, {irq_oe, irq_out});
      @(posedge pclk) usb_wake <= 2'h0;
      apb(0, 8'h10, 0);
      chk("wake flag", 1'b1, rd[0]);
      chk("irq kept", 1'b1, irq_oe);
      apb(1, 8'h10, 32'h01);
      tick(3);
      chk("irq released", 1'b0, irq_oe);
      @(posedge pclk) want_sor <= 2'h3;
      tick(4);
      chk("resume end", 2'h0, rk);
   endtask : t_wake
   // Swap is 1, so USB port B events land on embedded port 0
   task automatic t_disc;
      apb(1, 8'h04, 32'h06);
      apb(1, 8'h0C, 32'h06);
      @(posedge pclk) {want_l2, want_sor} <= 4'h0;
      @(posedge pclk) want_l2 <= 2'h1;
      tick(3);
      @(posedge pclk) se0 <= 2'h2;
      tick(4);
      chk("disc hide", 3'h4, {irq_oe, sef});
      apb(0, 8'h10, 0);
      chk("disc flag", 32'h02, rd);
      apb(1, 8'h10, 32'h02);
      tick(2);
      chk("disc cleared", 3'h0, {irq_oe, sef});
      @(posedge pclk) want_prst <= 2'h1;
      tick(3);
      chk("disc reinit", 2'h1, sef);
      @(posedge pclk) {want_prst, se0, att} <= 6'h02;
      tick(15);
      chk("attach early", 1'b0, irq_oe);
      tick(8);
      chk("attach irq", 3'h4, {irq_oe, atf});
      apb(1, 8'h04, 32'h02);
      tick(2);
      chk("attach fwd", 2'h1, atf);
      @(posedge pclk) att <= 2'h0;
      apb(0, 8'h10, 0);
      chk("attach flag", 32'h04, rd);
      apb(1, 8'h10, 32'h04);
   endtask : t_disc
   task automatic t_uart;
      @(posedge pclk) tpi <= 2'h1;
      tick(95);
      chk("uart early", 2'h0, uart);
      tick(10);
      chk("uart tune", 2'h1, uart);
      apb(1, 8'h00, 32'h40);
      tick(110);
      chk("uart off", 2'h0, uart);
      @(posedge pclk) gpz <= 0;
      tick(110);
      chk("uart gpz", 2'h1, uart);
   endtask : t_uart
   task automatic t_gpio;
      apb(1, 8'h08, 32'hC60A);
      apb(1, 8'h0C, 32'h40);
      tick(2);
      chk("gpio out", 6'h2A, {irq_oe, irq_out, tpoe, tpo});
      @(posedge pclk) tpi <= 2'h0;
      tick(3);
      chk("gpio irq", 2'h3, {irq_oe, irq_out});
      apb(1, 8'h10, 32'h40);
      tick(2);
      chk("gpio irq clr", 2'h2, {irq_oe, irq_out});
      apb(1, 8'h00, 32'h41);
      tick(3);
      chk("soft reset dir", 2'h0, tpoe);
      @(posedge pclk) gpz <= 1;
      tick(105);
      chk("uart gpz rise", 2'h0, uart);
      apb(1, 8'h00, 32'h4A);
      tick(105);
      chk("uart reg src", 2'h1, uart);
      @(posedge pclk) {rcm, gpz} <= 2'b00;
      tick(105);
      chk("reg mode off", 3'h0, {irq_oe, uart});
   endtask : t_gpio
   task automatic tally_and_finish;
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      tick(8);
      chk("power down", 1'b1, power_down);
      @(posedge pclk) presetn <= 1;
      tick(2);
      chk("awake", 1'b0, power_down);
      t_boot();
      t_wake();
      t_disc();
      t_uart();
      t_gpio();
      tally_and_finish();
   end
   initial begin
      #100us;
      n_fail++;
      tally_and_finish();
   end
endmodule : test_drm_top

// File: src/drm_defs.svh
// Offsets, field positions, reset values and timing counts of the repeater mode control
`ifndef DRM_DEFS_SVH
`define DRM_DEFS_SVH

`define DRM_CLK_MHZ 100
`define DRM_XLAT_US 1000
`define DRM_XLAT_CYC (`DRM_XLAT_US * `DRM_CLK_MHZ)
`define DRM_READY_CYC 200
`define DRM_MSW_US 1
`define DRM_MSW_CYC (`DRM_MSW_US * `DRM_CLK_MHZ)
`define DRM_DEB_US 60
`define DRM_DEB_CYC (`DRM_DEB_US * `DRM_CLK_MHZ)

`define DRM_OFF_CTRL 8'h00
`define DRM_OFF_PORT_EN 8'h04
`define DRM_OFF_GPIO_CFG 8'h08
`define DRM_OFF_INT_EN 8'h0C
`define DRM_OFF_INT_STAT 8'h10
`define DRM_OFF_STATUS 8'h14

`define DRM_CTRL_SRST 0
`define DRM_CTRL_SRC 1
`define DRM_CTRL_UREG 3
`define DRM_CTRL_PINSEL 5
`define DRM_CTRL_RST 7'h60
`define DRM_PORT_EN_RST 8'h00
`define DRM_GPIO_RST 16'h0000
`define DRM_INT_EN_RST 8'h00

`define DRM_G_DIR 0
`define DRM_G_PP 2
`define DRM_G_SEL 4
`define DRM_G_VAL 8
`define DRM_G_IEN 10
`define DRM_G_LVL 12
`define DRM_G_IRQ_PP 14
`define DRM_G_IRQ_POL 15

`endif

// File: src/drm_pkg.sv
// Types shared by the repeater mode control modules
package drm_pkg;
   typedef enum logic [2:0] {PS_L0, PS_L2, PS_ARES, PS_WIRQ, PS_DISC} drm_pstate_e;
   typedef enum logic [1:0] {GS_VAL, GS_IRQ, GS_UART, GS_READY} drm_gsel_e;
endpackage : drm_pkg

// File: src/drm_port_ctrl.sv
// Per-port resume, L2 interrupt and attach debounce controller
`timescale 1ns/1ps
`include "drm_defs.svh"
module drm_port_ctrl import drm_pkg::*; #(
   parameter int DEB_CYC = `DRM_DEB_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   drm_port_if.ctrl pif
);
   drm_pstate_e st;
   logic [15:0] deb_cnt;
   logic l2irq;
   logic att_arm;

   // Either L2 interrupt enable turns auto-resume off
   assign l2irq = pif.wake_irq_en | pif.disc_irq_en;
   assign att_arm = pif.active & pif.host & pif.att_irq_en & pif.usb_attach;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= PS_L0;
      end else if (!pif.active) begin
         st <= PS_L0;
      end else begin
         unique case (st)
            PS_L0: begin
               if (pif.host && pif.l2_cmd) begin
                  st <= PS_L2;
               end else if (pif.host && pif.suspended && pif.usb_wake && pif.auto_en &&
                     !l2irq) begin
                  st <= PS_ARES;
               end
            end
            PS_L2: begin
               if (pif.usb_wake) begin
                  if (l2irq) begin
                     st <= PS_WIRQ;
                  end else if (pif.auto_en) begin
                     st <= PS_ARES;
                  end else begin
                     st <= PS_L0;
                  end
               end else if (pif.usb_se0 && pif.disc_irq_en) begin
                  st <= PS_DISC;
               end else if (pif.sor) begin
                  st <= PS_L0;
               end
            end
            PS_ARES, PS_WIRQ: begin
               if (pif.sor) begin
                  st <= PS_L0;
               end
            end
            PS_DISC: begin
               if (pif.port_reset) begin
                  st <= PS_L0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deb_cnt <= 16'h0000;
      end else if (!att_arm) begin
         deb_cnt <= 16'h0000;
      end else if (deb_cnt != 16'(DEB_CYC)) begin
         deb_cnt <= deb_cnt + 16'h0001;
      end
   end

   // Resume K starts in the state's first cycle, far inside the hub deadline
   assign pif.resume_k = (st == PS_ARES) || (st == PS_WIRQ);
   assign pif.hold_rwake = (st == PS_ARES);
   assign pif.hold_se0 = (st == PS_WIRQ);
   assign pif.se0_fwd = pif.usb_se0 && (st != PS_DISC) &&
      !((st == PS_L2) && pif.disc_irq_en);
   assign pif.attach_fwd = pif.usb_attach && !(pif.host && pif.att_irq_en);
   assign pif.wake_evt = pif.active && (st == PS_L2) && pif.usb_wake && pif.wake_irq_en;
   assign pif.disc_evt = pif.active && (st == PS_L2) && !pif.usb_wake && pif.usb_se0 &&
      pif.disc_irq_en;
   assign pif.attach_evt = att_arm && (deb_cnt == 16'(DEB_CYC - 1));

   wake_irq_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
      pif.wake_evt |=> (st == PS_WIRQ) && pif.resume_k && !pif.hold_rwake)
      else $error("wake interrupt did not enter resume with se0 hold");
   disc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st == PS_DISC && pif.active && !pif.port_reset) |=> st == PS_DISC && !pif.se0_fwd)
      else $error("disconnect wait left early or reported se0");
   attach_deb_a: assert property (@(posedge pclk) disable iff (!presetn)
      pif.attach_evt |-> $past(att_arm, 8) && $past(att_arm, 1) && !pif.attach_fwd)
      else $error("attach interrupt without debounced attach");
endmodule : drm_port_ctrl

// File: src/drm_port_if.sv
// Signals between the top and one per-port wake and event controller
`timescale 1ns/1ps
interface drm_port_if;
   logic active;
   logic host;
   logic suspended;
   logic l2_cmd;
   logic usb_wake;
   logic usb_se0;
   logic usb_attach;
   logic sor;
   logic port_reset;
   logic auto_en;
   logic wake_irq_en;
   logic disc_irq_en;
   logic att_irq_en;
   logic resume_k;
   logic hold_rwake;
   logic hold_se0;
   logic se0_fwd;
   logic attach_fwd;
   logic wake_evt;
   logic disc_evt;
   logic attach_evt;
   modport ctrl (input active, host, suspended, l2_cmd, usb_wake, usb_se0, usb_attach, sor,
      port_reset, auto_en, wake_irq_en, disc_irq_en, att_irq_en,
      output resume_k, hold_rwake, hold_se0, se0_fwd, attach_fwd, wake_evt, disc_evt,
      attach_evt);
   modport top (output active, host, suspended, l2_cmd, usb_wake, usb_se0, usb_attach, sor,
      port_reset, auto_en, wake_irq_en, disc_irq_en, att_irq_en,
      input resume_k, hold_rwake, hold_se0, se0_fwd, attach_fwd, wake_evt, disc_evt,
      attach_evt);
endinterface : drm_port_if

// File: src/drm_top.sv
// Dual repeater mode control: crossbar latch, ready, UART bypass, L2 interrupts, GPIO
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "drm_defs.svh"
module drm_top import drm_pkg::*; #(
   parameter int XLAT_CYC = `DRM_XLAT_CYC,
   parameter int DEB_CYC = `DRM_DEB_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reg_ctrl_mode,
   input wire logic cross_sel,
   input wire logic general_pin_zero,
   input wire logic [1:0] tuning_pin_in,
   output logic [1:0] tuning_pin_out,
   output logic [1:0] tuning_pin_oe,
   output logic irq_output_pin_out,
   output logic irq_output_pin_oe,
   input wire logic [1:0] host_mode,
   input wire logic [1:0] suspended,
   input wire logic [1:0] l2_suspend_command,
   input wire logic [1:0] start_of_resume_signal,
   input wire logic [1:0] port_reset_ann,
   input wire logic [1:0] usb_wake,
   input wire logic [1:0] usb_se0,
   input wire logic [1:0] usb_attach,
   output logic power_down,
   output logic xbar_swap,
   output logic [1:0] rpt_ready,
   output logic [1:0] uart_bypass,
   output logic [1:0] usb_resume_k,
   output logic [1:0] emb_hold_rwake,
   output logic [1:0] emb_hold_se0,
   output logic [1:0] emb_se0_fwd,
   output logic [1:0] emb_attach_fwd,
   output logic [1:0] tuning_strap
);
   localparam int READY_CYC = `DRM_READY_CYC;
   localparam int MSW_CYC = `DRM_MSW_CYC;
   localparam int MSW_LIM = MSW_CYC + 1;

   logic int_rst;
   logic [16:0] seq_cnt;
   logic xbar_done;
   logic strap_done;
   logic [6:0] ctrl;
   logic [7:0] port_en;
   logic [15:0] gcfg;
   logic [7:0] int_en;
   logic [7:0] int_stat;
   logic [7:0] int_set;
   logic [1:0] uart_req;
   logic [1:0] tun_q;
   logic irq_act;
   logic wr;
   logic rd_setup;
   logic addr_ok;
   logic [31:0] rd_val;
   logic [7:0] w1c;
   drm_port_if pif[2] ();

   function automatic logic [1:0] pin_drive(input logic pp, input logic lvl);
      // Open-drain only ever pulls low; high comes from the pull-up
      pin_drive = pp ? {lvl, 1'b1} : {1'b0, ~lvl};
   endfunction : pin_drive

   assign wr = psel && penable && pready && pwrite;
   assign rd_setup = psel && !penable;
   assign irq_act = |(int_stat & int_en);
   assign w1c = (wr && paddr == `DRM_OFF_INT_STAT) ? pwdata[7:0] : 8'h00;

   always_comb begin
      addr_ok = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr)
         `DRM_OFF_CTRL: rd_val = {25'h0, ctrl[6:1], 1'b0};
         `DRM_OFF_PORT_EN: rd_val = {24'h0, port_en};
         `DRM_OFF_GPIO_CFG: rd_val = {16'h0, gcfg};
         `DRM_OFF_INT_EN: rd_val = {24'h0, int_en};
         `DRM_OFF_INT_STAT: rd_val = {24'h0, int_stat};
         `DRM_OFF_STATUS: rd_val = {22'h0, tuning_strap, tun_q, uart_bypass, rpt_ready,
            xbar_done, xbar_swap};
         default: addr_ok = 1'b0;
      endcase
   end

   // Zero-wait slave: answer prepared in setup, pready high through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= rd_setup;
         pslverr <= rd_setup && !addr_ok;
         if (rd_setup && !pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `DRM_CTRL_RST;
         port_en <= `DRM_PORT_EN_RST;
         int_en <= `DRM_INT_EN_RST;
      end else begin
         ctrl[`DRM_CTRL_SRST] <= wr && paddr == `DRM_OFF_CTRL && pwdata[`DRM_CTRL_SRST];
         if (wr && paddr == `DRM_OFF_CTRL) begin
            ctrl[6:1] <= pwdata[6:1];
         end
         if (wr && paddr == `DRM_OFF_PORT_EN) begin
            port_en <= pwdata[7:0];
         end
         if (wr && paddr == `DRM_OFF_INT_EN) begin
            int_en <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcfg <= `DRM_GPIO_RST;
      end else if (ctrl[`DRM_CTRL_SRST]) begin
         gcfg[`DRM_G_DIR +: 2] <= 2'b00;
      end else if (wr && paddr == `DRM_OFF_GPIO_CFG) begin
         gcfg <= pwdata[15:0];
      end
   end

   // Reset sequence: one cycle of internal reset, then the counts run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_rst <= 1'b1;
         seq_cnt <= 17'h00000;
         power_down <= 1'b1;
      end else begin
         int_rst <= 1'b0;
         power_down <= 1'b0;
         if (!int_rst && seq_cnt != 17'h1FFFF) begin
            seq_cnt <= seq_cnt + 17'h00001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xbar_done <= 1'b0;
         xbar_swap <= 1'b0;
      end else if (!xbar_done && !int_rst && seq_cnt == 17'(XLAT_CYC - 1)) begin
         xbar_done <= 1'b1;
         xbar_swap <= cross_sel;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpt_ready <= 2'b00;
      end else if (!int_rst && seq_cnt == 17'(READY_CYC - 1)) begin
         rpt_ready <= 2'b11;
      end
   end

   // Straps are caught on the first edge after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done <= 1'b0;
         tuning_strap <= 2'b00;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         tuning_strap <= tuning_pin_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tun_q <= 2'b00;
      end else begin
         tun_q <= tuning_pin_in;
      end
   end

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         logic [6:0] msw_cnt;
         logic [1:0] gsel;
         logic gval;
         logic [1:0] drv;

         // Pin source: tuning pin active high, or general pin zero active low
         always_comb begin
            if (ctrl[`DRM_CTRL_SRC + p]) begin
               uart_req[p] = ctrl[`DRM_CTRL_UREG + p];
            end else if (ctrl[`DRM_CTRL_PINSEL + p]) begin
               uart_req[p] = tuning_pin_in[p] && !gcfg[`DRM_G_DIR + p];
            end else begin
               uart_req[p] = !general_pin_zero;
            end
            uart_req[p] = uart_req[p] && reg_ctrl_mode && rpt_ready[p];
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               msw_cnt <= 7'h00;
               uart_bypass[p] <= 1'b0;
            end else if (uart_req[p] == uart_bypass[p]) begin
               msw_cnt <= 7'h00;
            end else if (msw_cnt == 7'(MSW_CYC - 1)) begin
               msw_cnt <= 7'h00;
               uart_bypass[p] <= uart_req[p];
            end else begin
               msw_cnt <= msw_cnt + 7'h01;
            end
         end

         // USB-side inputs reach the embedded port that the crossbar assigns
         assign pif[p].active = rpt_ready[p] && !uart_bypass[p];
         assign pif[p].host = host_mode[p];
         assign pif[p].suspended = suspended[p];
         assign pif[p].l2_cmd = l2_suspend_command[p];
         assign pif[p].sor = start_of_resume_signal[p];
         assign pif[p].port_reset = port_reset_ann[p];
         assign pif[p].usb_wake = usb_wake[p ^ xbar_swap];
         assign pif[p].usb_se0 = usb_se0[p ^ xbar_swap];
         assign pif[p].usb_attach = usb_attach[p ^ xbar_swap];
         assign pif[p].wake_irq_en = port_en[4 * p];
         assign pif[p].disc_irq_en = port_en[4 * p + 1];
         assign pif[p].att_irq_en = port_en[4 * p + 2];
         assign pif[p].auto_en = port_en[4 * p + 3];

         drm_port_ctrl #(.DEB_CYC(DEB_CYC)) u_ctrl (
            .pclk(pclk),
            .presetn(presetn),
            .pif(pif[p])
         );

         assign int_set[3 * p] = pif[p].wake_evt;
         assign int_set[3 * p + 1] = pif[p].disc_evt;
         assign int_set[3 * p + 2] = pif[p].attach_evt;
         assign int_set[6 + p] = !gcfg[`DRM_G_DIR + p] && gcfg[`DRM_G_IEN + p] &&
            (gcfg[`DRM_G_LVL + p] ? tuning_pin_in[p] : tuning_pin_in[p] != tun_q[p]);

         assign gsel = gcfg[`DRM_G_SEL + 2 * p +: 2];
         always_comb begin
            unique case (drm_gsel_e'(gsel))
               GS_VAL: gval = gcfg[`DRM_G_VAL + p];
               GS_IRQ: gval = irq_act;
               GS_UART: gval = uart_bypass[p];
               GS_READY: gval = rpt_ready[p];
            endcase
         end
         assign drv = pin_drive(gcfg[`DRM_G_PP + p], gval);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tuning_pin_out[p] <= 1'b0;
               tuning_pin_oe[p] <= 1'b0;
               usb_resume_k[p] <= 1'b0;
               emb_hold_rwake[p] <= 1'b0;
               emb_hold_se0[p] <= 1'b0;
               emb_se0_fwd[p] <= 1'b0;
               emb_attach_fwd[p] <= 1'b0;
            end else begin
               tuning_pin_out[p] <= drv[1];
               tuning_pin_oe[p] <= drv[0] && gcfg[`DRM_G_DIR + p] && reg_ctrl_mode;
               usb_resume_k[p] <= xbar_swap ? pif[1 - p].resume_k :
                  pif[p].resume_k;
               emb_hold_rwake[p] <= pif[p].hold_rwake;
               emb_hold_se0[p] <= pif[p].hold_se0;
               emb_se0_fwd[p] <= pif[p].se0_fwd;
               emb_attach_fwd[p] <= pif[p].attach_fwd;
            end
         end
      end
   endgenerate

   // Set beats a same-cycle write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= 8'h00;
      end else begin
         int_stat <= (int_stat & ~w1c) | int_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_output_pin_out <= 1'b0;
         irq_output_pin_oe <= 1'b0;
      end else begin
         {irq_output_pin_out, irq_output_pin_oe} <= pin_drive(gcfg[`DRM_G_IRQ_PP],
            gcfg[`DRM_G_IRQ_POL] ? irq_act : !irq_act);
         if (!reg_ctrl_mode) begin
            irq_output_pin_oe <= 1'b0;
         end
      end
   end

   xbar_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(xbar_done) |-> seq_cnt == 17'(XLAT_CYC) && xbar_swap == $past(cross_sel))
      else $error("crossbar latched at wrong time or value");
   xbar_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      xbar_done |=> xbar_done && $stable(xbar_swap))
      else $error("crossbar orientation changed after latch");
   ready_time_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rpt_ready[0]) |-> seq_cnt == 17'(READY_CYC) && !power_down)
      else $error("repeater ready at wrong time");
   uart_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(uart_req[0]) |-> ##[1:MSW_LIM] (!uart_bypass[0] || uart_req[0]))
      else $error("uart bypass not left within switch time");
   uart_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[`DRM_CTRL_SRC] && rpt_ready[0] && reg_ctrl_mode) |->
      uart_req[0] == ctrl[`DRM_CTRL_UREG])
      else $error("register uart source not honoured");
   irq_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      (int_stat[1] && !w1c[1]) |=> int_stat[1])
      else $error("interrupt flag dropped without clear");
   irq_od_a: assert property (@(posedge pclk) disable iff (!presetn)
      (reg_ctrl_mode && !gcfg[`DRM_G_IRQ_PP] && irq_act) |=>
      irq_output_pin_oe && !irq_output_pin_out)
      else $error("open-drain interrupt pin not pulled low");
   gpio_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      (int_set[6] && !gcfg[`DRM_G_LVL]) |->
      $past(tuning_pin_in[0]) != tuning_pin_in[0] ##1 int_stat[6])
      else $error("gpio edge event not flagged");
endmodule : drm_top
